// ### core/gpb_pkg.sv
// package: register map, field positions, reset values and pin bundles for the port block
package gpb_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_KP_DATA = 10'h006;
	localparam logic [9:0] IDX_PC_DATA = 10'h007;
	localparam logic [9:0] IDX_PP_DATA = 10'h008;
	localparam logic [9:0] IDX_INT_CTRL = 10'h00B;
	localparam logic [9:0] IDX_OPTION = 10'h081;
	localparam logic [9:0] IDX_KP_DIR = 10'h086;
	localparam logic [9:0] IDX_PC_DIR = 10'h087;
	localparam logic [9:0] IDX_PP_DIR = 10'h088;
	localparam logic [9:0] IDX_CTL_DIR = 10'h089;
	// reset values
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [7:0] RST_CTL_DIR = 8'h07;
	localparam logic [7:0] RST_DATA_POR = 8'h00;
	localparam logic [7:0] RST_INT_CTRL = 8'h00;
	// field positions
	localparam int OPT_PULLUP_DISABLE_N = 7;
	localparam int OPT_EXT_IRQ_EDGE = 6;
	localparam int INT_PORT_CHANGE_FLAG = 0;
	localparam int INT_EXT_IRQ_FLAG = 1;
	localparam int INT_EXT_IRQ_ENABLE = 4;
	localparam int CTL_PARALLEL_SLAVE_EN = 4;
	localparam int CTL_UNIMPL = 3;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h37;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		GPB_SEL_NONE = 4'h0,
		GPB_SEL_KP_DATA = 4'h1,
		GPB_SEL_PC_DATA = 4'h2,
		GPB_SEL_PP_DATA = 4'h3,
		GPB_SEL_INT_CTRL = 4'h4,
		GPB_SEL_OPTION = 4'h5,
		GPB_SEL_KP_DIR = 4'h6,
		GPB_SEL_PC_DIR = 4'h7,
		GPB_SEL_PP_DIR = 4'h8,
		GPB_SEL_CTL_DIR = 4'h9
	} gpb_sel_t;

	typedef enum logic [0:0] {
		GPB_ST_IDLE = 1'b0,
		GPB_ST_RESP = 1'b1
	} gpb_state_t;

	// driven side of one 8-bit port: level to drive and driver enable
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe;
	} gpb_pins_t;
endpackage

// ### core/gpb_ports.sv
// three 8-bit general purpose ports with an AXI4-Lite register slave
// Functional notes
// R1 - eight keypad pins are general I/O, each with software-enabled weak pull-up
// R2 - keypad bit 0 is external interrupt input, hysteresis path when so configured
// R3 - only keypad bits 4 to 7 raise change interrupts
// R4 - keypad bit 6 is programming clock, bit 7 programming data in programming mode
// R5 - keypad bit 7 uses hysteresis in programming mode, normal path otherwise
// R6 - all three direction registers reset to all ones, pins inputs
// R7 - keypad and parallel data latches set only at power-on, kept otherwise
// R8 - peripheral port is eight bits, each pin's direction its own bit
// R9 - enabled peripheral overrides pin direction, forcing output or input
// R10 - software avoids read-modify-write of peripheral direction while overridden
// R11 - peripheral bits 0 to 2 carry timer oscillator and capture/compare channels
// R12 - peripheral bits 3 to 5 carry serial clock, serial data in, serial out
// R13 - peripheral bits 6 and 7 carry USART transmit/clock and receive/data
// R14 - reduced member leaves channel 2 and USART unconnected to the pins
// R15 - parallel port has eight pins, each input or output in port mode
// R16 - control direction bit 4 turns parallel port into slave data bus
// R17 - in slave mode parallel pin n carries slave bus bit n
// R18 - parallel pins use hysteresis in port mode, normal path in slave mode
// R19 - control direction bit 3 always reads zero
// R20 - direction one floats the driver, zero drives the output latch
// R21 - option bit 7 low enables pull-ups except on outputs; off after power-on
// R22 - inputs 4 to 7 compared to value at last read set change flag; the code also reloads that value on keypad data writes
// R23 - override touches only the driver; stored direction bit is kept
//
// Local design decision: the AXI4-Lite slave port.
module gpb_ports
	import gpb_pkg::*;
#(
	parameter bit REDUCED = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic por_b_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [DATA_W-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [7:0] keypad_port_in,
	output gpb_pins_t keypad_port_out,
	output logic [7:0] keypad_pullup_en_out,
	output logic [7:0] keypad_schmitt_sel_out,
	input wire logic prog_mode_in,
	input wire logic prog_data_level_in,
	input wire logic prog_data_oe_in,
	output logic prog_clk_out,
	output logic prog_data_out,
	output logic ext_irq_level_out,
	output logic ext_irq_flag_out,
	output logic port_change_flag_out,
	input wire logic [7:0] peripheral_port_in,
	output gpb_pins_t peripheral_port_out,
	input wire logic [7:0] periph_override_en_in,
	input wire logic [7:0] periph_override_dir_in,
	input wire logic [7:0] periph_level_in,
	input wire logic timer_osc_en_in,
	output logic [7:0] periph_pin_level_out,
	input wire logic [7:0] parallel_port_in,
	output gpb_pins_t parallel_port_out,
	output logic [7:0] parallel_schmitt_sel_out,
	input wire logic [7:0] parallel_slave_bus_level_in,
	input wire logic parallel_slave_bus_oe_in,
	input wire logic [2:0] parallel_slave_status_in,
	output logic parallel_slave_enable_out,
	output logic [7:0] parallel_slave_bus_out
);
	logic [7:0] kp_meta, kp_sync, pc_meta, pc_sync, pp_meta, pp_sync;
	logic prog_meta, prog_sync;
	logic [7:0] kp_data, pc_data, pp_data;
	logic [7:0] kp_dir, pc_dir, pp_dir, ctl_dir, option_ctrl;
	logic [7:0] int_ctrl;
	logic [7:4] kp_last_read;
	logic ext_prev;
	gpb_state_t wr_state, rd_state;
	logic have_aw, have_w;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0] w_data;
	logic w_lane0;
	logic do_write, kp_read, kp_write;
	gpb_sel_t wr_sel, rd_sel;
	logic [7:0] rd_byte;
	logic [7:0] pc_ovr_en, next_pc_dir_eff, next_pc_level;
	logic kp_mismatch, ext_edge, pslave;

	function automatic gpb_sel_t decode(input logic [ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = addr[ADDR_W-1:2];
		if (addr[1:0] != 2'h0)
			decode = GPB_SEL_NONE;
		else if (idx == IDX_KP_DATA)
			decode = GPB_SEL_KP_DATA;
		else if (idx == IDX_PC_DATA)
			decode = GPB_SEL_PC_DATA;
		else if (idx == IDX_PP_DATA)
			decode = GPB_SEL_PP_DATA;
		else if (idx == IDX_INT_CTRL)
			decode = GPB_SEL_INT_CTRL;
		else if (idx == IDX_OPTION)
			decode = GPB_SEL_OPTION;
		else if (idx == IDX_KP_DIR)
			decode = GPB_SEL_KP_DIR;
		else if (idx == IDX_PC_DIR)
			decode = GPB_SEL_PC_DIR;
		else if (idx == IDX_PP_DIR)
			decode = GPB_SEL_PP_DIR;
		else if (idx == IDX_CTL_DIR)
			decode = GPB_SEL_CTL_DIR;
		else
			decode = GPB_SEL_NONE;
	endfunction

	// pins and the mode strap come from outside: two flops first
	always_ff @(posedge ref_clk_in) begin
		kp_meta <= keypad_port_in;
		kp_sync <= kp_meta;
		pc_meta <= peripheral_port_in;
		pc_sync <= pc_meta;
		pp_meta <= parallel_port_in;
		pp_sync <= pp_meta;
		prog_meta <= prog_mode_in;
		prog_sync <= prog_meta;
	end

	// write channel: address and data taken in either order
	assign do_write = have_aw && have_w && (wr_state == GPB_ST_IDLE);
	assign wr_sel = decode(aw_addr);
	assign kp_write = do_write && w_lane0 && (wr_sel == GPB_SEL_KP_DATA);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			wr_state <= GPB_ST_IDLE;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw_addr <= '0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else begin
			case (wr_state)
				GPB_ST_IDLE: begin
					if (s_axi_awvalid_in && s_axi_awready_out) begin
						have_aw <= 1'b1;
						aw_addr <= s_axi_awaddr_in;
						s_axi_awready_out <= 1'b0;
					end else if (!have_aw) begin
						s_axi_awready_out <= 1'b1;
					end
					if (s_axi_wvalid_in && s_axi_wready_out) begin
						have_w <= 1'b1;
						w_data <= s_axi_wdata_in[7:0];
						w_lane0 <= s_axi_wstrb_in[0];
						s_axi_wready_out <= 1'b0;
					end else if (!have_w) begin
						s_axi_wready_out <= 1'b1;
					end
					if (do_write) begin
						wr_state <= GPB_ST_RESP;
						s_axi_bvalid_out <= 1'b1;
						s_axi_bresp_out <= (wr_sel == GPB_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
					end
				end
				GPB_ST_RESP: begin
					if (s_axi_bready_in) begin
						wr_state <= GPB_ST_IDLE;
						s_axi_bvalid_out <= 1'b0;
						have_aw <= 1'b0;
						have_w <= 1'b0;
						s_axi_awready_out <= 1'b1;
						s_axi_wready_out <= 1'b1;
					end
				end
				default: begin
					wr_state <= GPB_ST_IDLE;
				end
			endcase
		end
	end

	// read channel: one cycle from address to data
	assign rd_sel = decode(s_axi_araddr_in);
	assign kp_read = s_axi_arvalid_in && s_axi_arready_out && (rd_sel == GPB_SEL_KP_DATA);

	always_comb begin
		case (rd_sel)
			GPB_SEL_KP_DATA: rd_byte = kp_sync;
			GPB_SEL_PC_DATA: rd_byte = pc_sync;
			GPB_SEL_PP_DATA: rd_byte = pp_sync;
			GPB_SEL_INT_CTRL: rd_byte = int_ctrl;
			GPB_SEL_OPTION: rd_byte = option_ctrl;
			GPB_SEL_KP_DIR: rd_byte = kp_dir;
			GPB_SEL_PC_DIR: rd_byte = pc_dir;
			GPB_SEL_PP_DIR: rd_byte = pp_dir;
			GPB_SEL_CTL_DIR: rd_byte = {parallel_slave_status_in[2:1], ctl_dir[5:4], 1'b0,
				ctl_dir[2:0]}; // R19
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rd_state <= GPB_ST_IDLE;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= '0;
			s_axi_rresp_out <= RESP_OKAY;
		end else begin
			case (rd_state)
				GPB_ST_IDLE: begin
					if (s_axi_arvalid_in && s_axi_arready_out) begin
						rd_state <= GPB_ST_RESP;
						s_axi_arready_out <= 1'b0;
						s_axi_rvalid_out <= 1'b1;
						s_axi_rdata_out <= {24'h000000, rd_byte};
						s_axi_rresp_out <= (rd_sel == GPB_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
					end else begin
						s_axi_arready_out <= 1'b1;
					end
				end
				GPB_ST_RESP: begin
					if (s_axi_rready_in) begin
						rd_state <= GPB_ST_IDLE;
						s_axi_rvalid_out <= 1'b0;
						s_axi_arready_out <= 1'b1;
					end
				end
				default: begin
					rd_state <= GPB_ST_IDLE;
				end
			endcase
		end
	end

	// data latches: cleared only by power-on, untouched by other resets
	always_ff @(posedge ref_clk_in) begin
		if (!por_b_in) begin
			kp_data <= RST_DATA_POR; // R7
			pp_data <= RST_DATA_POR; // R7
			pc_data <= RST_DATA_POR;
		end else if (do_write && w_lane0) begin
			if (wr_sel == GPB_SEL_KP_DATA)
				kp_data <= w_data;
			if (wr_sel == GPB_SEL_PC_DATA)
				pc_data <= w_data;
			if (wr_sel == GPB_SEL_PP_DATA)
				pp_data <= w_data;
		end
	end

	// control registers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !por_b_in) begin
			kp_dir <= RST_DIR; // R6
			pc_dir <= RST_DIR; // R6
			pp_dir <= RST_DIR; // R6
			option_ctrl <= RST_OPTION; // R21
			ctl_dir <= RST_CTL_DIR;
		end else if (do_write && w_lane0) begin
			case (wr_sel)
				GPB_SEL_KP_DIR: kp_dir <= w_data;
				GPB_SEL_PC_DIR: pc_dir <= w_data; // R8 R23
				GPB_SEL_PP_DIR: pp_dir <= w_data;
				GPB_SEL_OPTION: option_ctrl <= w_data;
				GPB_SEL_CTL_DIR: ctl_dir <= w_data & CTL_WRITE_MASK;
				default: ;
			endcase
		end
	end

	// change detect on input-configured upper keypad pins
	assign kp_mismatch = |((kp_sync[7:4] ^ kp_last_read) & kp_dir[7:4]); // R3 R22
	assign ext_edge = int_ctrl[INT_EXT_IRQ_ENABLE] &&
		(option_ctrl[OPT_EXT_IRQ_EDGE] ? (kp_sync[0] && !ext_prev) : (!kp_sync[0] && ext_prev));

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !por_b_in) begin
			kp_last_read <= 4'h0;
			ext_prev <= 1'b0;
			int_ctrl <= RST_INT_CTRL;
		end else begin
			ext_prev <= kp_sync[0];
			if (kp_read || kp_write)
				kp_last_read <= kp_sync[7:4]; // R22
			if (do_write && w_lane0 && wr_sel == GPB_SEL_INT_CTRL)
				int_ctrl <= w_data;
			// a hardware set in the clearing cycle wins
			if (kp_mismatch)
				int_ctrl[INT_PORT_CHANGE_FLAG] <= 1'b1; // R22
			if (ext_edge)
				int_ctrl[INT_EXT_IRQ_FLAG] <= 1'b1; // R2
		end
	end

	// peripheral override: reduced member loses channel 2 and USART
	always_comb begin
		pc_ovr_en = periph_override_en_in;
		if (REDUCED) begin
			pc_ovr_en[6] = 1'b0; // R14
			pc_ovr_en[7] = 1'b0; // R14
			pc_ovr_en[1] = periph_override_en_in[1] && timer_osc_en_in; // R14
		end
		for (int i = 0; i < PORT_W; i++) begin
			next_pc_dir_eff[i] = pc_ovr_en[i] ? periph_override_dir_in[i] : pc_dir[i]; // R9 R23
			next_pc_level[i] = pc_ovr_en[i] ? periph_level_in[i] : pc_data[i]; // R11 R12 R13
		end
	end

	assign pslave = ctl_dir[CTL_PARALLEL_SLAVE_EN];

	// pin drivers, all registered
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !por_b_in) begin
			keypad_port_out <= '0;
			peripheral_port_out <= '0;
			parallel_port_out <= '0;
			keypad_pullup_en_out <= 8'h00;
			keypad_schmitt_sel_out <= 8'h00;
			parallel_schmitt_sel_out <= 8'hFF;
			prog_clk_out <= 1'b0;
			prog_data_out <= 1'b0;
			ext_irq_level_out <= 1'b0;
			ext_irq_flag_out <= 1'b0;
			port_change_flag_out <= 1'b0;
			periph_pin_level_out <= 8'h00;
			parallel_slave_enable_out <= 1'b0;
			parallel_slave_bus_out <= 8'h00;
		end else begin
			keypad_port_out.level <= kp_data; // R20
			keypad_port_out.oe <= ~kp_dir; // R1 R20
			if (prog_sync) begin
				keypad_port_out.oe[6] <= 1'b0; // R4
				keypad_port_out.oe[7] <= prog_data_oe_in; // R4
				keypad_port_out.level[7] <= prog_data_level_in; // R4
			end
			keypad_pullup_en_out <= option_ctrl[OPT_PULLUP_DISABLE_N] ? 8'h00 : kp_dir; // R1 R21
			keypad_schmitt_sel_out <= {prog_sync, prog_sync, 5'h00,
				int_ctrl[INT_EXT_IRQ_ENABLE]}; // R2 R4 R5
			prog_clk_out <= prog_sync && kp_sync[6]; // R4
			prog_data_out <= prog_sync && kp_sync[7]; // R4
			ext_irq_level_out <= kp_sync[0]; // R2
			ext_irq_flag_out <= int_ctrl[INT_EXT_IRQ_FLAG];
			port_change_flag_out <= int_ctrl[INT_PORT_CHANGE_FLAG];
			peripheral_port_out.level <= next_pc_level;
			peripheral_port_out.oe <= ~next_pc_dir_eff; // R8 R9
			periph_pin_level_out <= pc_sync;
			parallel_slave_enable_out <= pslave; // R16
			parallel_schmitt_sel_out <= pslave ? 8'h00 : 8'hFF; // R18
			if (pslave) begin
				parallel_port_out.level <= parallel_slave_bus_level_in; // R17
				parallel_port_out.oe <= {PORT_W{parallel_slave_bus_oe_in}}; // R16 R17
				parallel_slave_bus_out <= pp_sync; // R17
			end else begin
				parallel_port_out.level <= pp_data; // R15
				parallel_port_out.oe <= ~pp_dir; // R15 R20
				parallel_slave_bus_out <= 8'h00;
			end
		end
	end
endmodule

// ### verification/gpb_ports_asserts.sv
// concurrent checks on the port block's pins and register bus
module gpb_ports_asserts
	import gpb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic por_b_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [DATA_W-1:0] s_axi_rdata_out,
	input wire gpb_pins_t keypad_port_out,
	input wire gpb_pins_t peripheral_port_out,
	input wire gpb_pins_t parallel_port_out,
	input wire logic [7:0] keypad_pullup_en_out,
	input wire logic prog_mode_in,
	input wire logic prog_clk_out,
	input wire logic prog_data_out,
	input wire logic [7:0] periph_override_en_in,
	input wire logic [7:0] periph_override_dir_in,
	input wire logic [7:0] periph_level_in,
	input wire logic [7:0] parallel_schmitt_sel_out,
	input wire logic parallel_slave_enable_out,
	input wire logic [7:0] parallel_slave_bus_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rst_ok;
	assign rst_ok = rst_b_in && por_b_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_ok);
	sequence s_aw_take;
		s_axi_awvalid_in && s_axi_awready_out;
	endsequence
	sequence s_ar_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	AST_PINS_RESET: assert property (disable iff (1'b0) !rst_ok |=>
		(keypad_port_out.oe | peripheral_port_out.oe | parallel_port_out.oe) == 8'h00)
		else $error("driver enabled right after reset");
	AST_PULLUP_INPUTS: assert property ((keypad_pullup_en_out & keypad_port_out.oe) == 8'h00)
		else $error("pull-up on an output pin");
	AST_OVR_OUT: assert property (periph_override_en_in[2] && !periph_override_dir_in[2] |=>
		peripheral_port_out.oe[2] && peripheral_port_out.level[2] == $past(periph_level_in[2]))
		else $error("output override not applied");
	AST_OVR_IN: assert property (periph_override_en_in[4] && periph_override_dir_in[4] |=>
		!peripheral_port_out.oe[4])
		else $error("input override not applied");
	AST_PROG_IDLE: assert property (!prog_mode_in [*4] |-> !prog_clk_out && !prog_data_out)
		else $error("programming lines active outside programming mode");
	AST_SLAVE_IDLE: assert property (!parallel_slave_enable_out [*2] |->
		parallel_slave_bus_out == 8'h00)
		else $error("slave bus active in port mode");
	AST_PP_SCHMITT: assert property (parallel_schmitt_sel_out ==
		(parallel_slave_enable_out ? 8'h00 : 8'hFF))
		else $error("parallel input path wrong for mode");
	AST_AW_BUSY: assert property (s_aw_take |=> !s_axi_awready_out [*2])
		else $error("second write accepted too early");
	AST_AR_ANSWER: assert property (s_ar_take |=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped before accepted");
endmodule

bind gpb_ports gpb_ports_asserts chk_u (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_rdata_out(s_axi_rdata_out), .keypad_port_out(keypad_port_out),
	.peripheral_port_out(peripheral_port_out), .parallel_port_out(parallel_port_out),
	.keypad_pullup_en_out(keypad_pullup_en_out), .prog_mode_in(prog_mode_in),
	.prog_clk_out(prog_clk_out), .prog_data_out(prog_data_out),
	.periph_override_en_in(periph_override_en_in),
	.periph_override_dir_in(periph_override_dir_in), .periph_level_in(periph_level_in),
	.parallel_schmitt_sel_out(parallel_schmitt_sel_out),
	.parallel_slave_enable_out(parallel_slave_enable_out),
	.parallel_slave_bus_out(parallel_slave_bus_out)
);

// ### verification/gpb_far_side.sv
// pin model: resolves each port line from drivers, pull-ups and bench stimulus
module gpb_far_side
	import gpb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire gpb_pins_t kp_in,
	input wire gpb_pins_t pc_in,
	input wire gpb_pins_t pp_in,
	input wire logic [7:0] pu_in,
	input wire logic [23:0] ext_lvl_in,
	input wire logic [23:0] ext_en_in,
	output logic [7:0] kp_lvl_out,
	output logic [7:0] pc_lvl_out,
	output logic [7:0] pp_lvl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	always_ff @(posedge ref_clk_in) tog <= ~tog;
	// undriven lines wander so a stale value never passes
	function automatic logic [7:0] res(gpb_pins_t p, logic [7:0] e, l, u, logic t);
		return (p.oe & p.level) | (~p.oe & e & l) | (~p.oe & ~e & (u | {8{t}}));
	endfunction
	assign kp_lvl_out = res(kp_in, ext_en_in[7:0], ext_lvl_in[7:0], pu_in, tog);
	assign pc_lvl_out = res(pc_in, ext_en_in[15:8], ext_lvl_in[15:8], 8'h00, tog);
	assign pp_lvl_out = res(pp_in, ext_en_in[23:16], ext_lvl_in[23:16], 8'h00, tog);
endmodule

// ### verification/testbench.sv
// self-checking bench for the three-port block
module testbench import gpb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 1'b0;
	logic rst_b_in, por_b_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
	logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
	logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, prog_mode_in;
	logic prog_data_level_in, prog_data_oe_in, prog_clk_out, prog_data_out, ext_irq_level_out;
	logic ext_irq_flag_out, port_change_flag_out, timer_osc_en_in, parallel_slave_bus_oe_in;
	logic parallel_slave_enable_out;
	logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
	logic [7:0] keypad_port_in, keypad_pullup_en_out, keypad_schmitt_sel_out, peripheral_port_in;
	logic [7:0] periph_override_en_in, periph_override_dir_in, periph_level_in;
	logic [7:0] periph_pin_level_out, parallel_port_in, parallel_schmitt_sel_out;
	logic [7:0] parallel_slave_bus_level_in, parallel_slave_bus_out;
	logic [2:0] parallel_slave_status_in;
	logic [23:0] ext_lvl, ext_en;
	gpb_pins_t keypad_port_out, peripheral_port_out, parallel_port_out;
	int n_errors = 0;
	int check_count = 0;
	always #4 ref_clk_in = ~ref_clk_in;
	gpb_ports dut_u (.*);
	gpb_far_side far_u (.ref_clk_in(ref_clk_in), .kp_in(keypad_port_out),
		.pc_in(peripheral_port_out), .pp_in(parallel_port_out), .pu_in(keypad_pullup_en_out),
		.ext_lvl_in(ext_lvl), .ext_en_in(ext_en), .kp_lvl_out(keypad_port_in),
		.pc_lvl_out(peripheral_port_in), .pp_lvl_out(parallel_port_in));
	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		@(posedge ref_clk_in);
		s_axi_awaddr_in <= {i, 2'b00};
		s_axi_wdata_in <= {24'h0, d};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		rsp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] i);
		@(posedge ref_clk_in);
		s_axi_araddr_in <= {i, 2'b00};
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		rdat = s_axi_rdata_out;
		rsp = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask
	task automatic rc(input logic [9:0] i, input logic [31:0] e, input string n);
		rd(i);
		chk(n, e, rdat);
	endtask
	task automatic settle;
		repeat (4) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic pulse(input bit p);
		@(posedge ref_clk_in);
		if (p) por_b_in <= 1'b0;
		else rst_b_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		por_b_in <= 1'b1;
	endtask
	task automatic t_rst;
		rc(IDX_KP_DIR, 32'hFF, "kp_dir");
		rc(IDX_PC_DIR, 32'hFF, "pc_dir");
		rc(IDX_PP_DIR, 32'hFF, "pp_dir");
		rc(IDX_OPTION, 32'hFF, "option");
		rc(IDX_CTL_DIR, 32'h07, "ctl_dir");
		rd(10'h3FF);
		chk("unmapped_resp", 32'(RESP_SLVERR), 32'(rsp));
	endtask
	task automatic t_latch;
		wr(IDX_PP_DATA, 8'hA5);
		wr(IDX_PP_DIR, 8'h0F);
		ext_lvl <= 24'h030000;
		ext_en <= 24'h0F0000;
		settle();
		chk("pp_oe", 32'hF0, parallel_port_out.oe);
		chk("pp_level", 32'hA0, parallel_port_out.level & 8'hF0);
		rc(IDX_PP_DATA, 32'hA3, "pp_pins");
		pulse(1'b0);
		wr(IDX_PP_DIR, 8'h00);
		settle();
		chk("pp_kept", 32'hA5, parallel_port_out.level);
		pulse(1'b1);
		wr(IDX_PP_DIR, 8'h00);
		settle();
		chk("pp_por", 32'(RST_DATA_POR), parallel_port_out.level);
		wr(IDX_PP_DIR, 8'hFF);
		ext_en <= 24'h0;
	endtask
	task automatic t_pull;
		wr(IDX_KP_DIR, 8'hF0);
		wr(IDX_OPTION, 8'h7F);
		settle();
		chk("pullup_on", 32'hF0, keypad_pullup_en_out);
		rc(IDX_KP_DATA, 32'hF0, "kp_pulled");
		wr(IDX_OPTION, 8'hFF);
		settle();
		chk("pullup_off", 32'h00, keypad_pullup_en_out);
		wr(IDX_KP_DIR, 8'hFF);
	endtask
	task automatic t_chg;
		ext_lvl <= 24'h000000;
		ext_en <= 24'h0000FF;
		settle();
		rd(IDX_KP_DATA);
		wr(IDX_INT_CTRL, 8'h00);
		ext_lvl <= 24'h00000F;
		settle();
		chk("low_change", 32'h0, port_change_flag_out);
		rd(IDX_KP_DATA);
		ext_lvl <= 24'h00002F;
		settle();
		chk("high_change", 32'h1, port_change_flag_out);
		rc(IDX_INT_CTRL, 32'h01, "int_ctrl");
		rd(IDX_KP_DATA);
		wr(IDX_INT_CTRL, 8'h10);
		settle();
		chk("irq_schmitt", 32'h01, keypad_schmitt_sel_out & 8'h01);
		chk("irq_level", 32'h1, ext_irq_level_out);
		@(posedge ref_clk_in);
		ext_lvl <= 24'h00002E;
		settle();
		chk("irq_low", 32'h0, ext_irq_level_out);
		chk("irq_fall", 32'h0, ext_irq_flag_out);
		@(posedge ref_clk_in);
		ext_lvl <= 24'h00002F;
		settle();
		chk("irq_flag", 32'h1, ext_irq_flag_out);
		chk("bit0_change", 32'h0, port_change_flag_out);
		wr(IDX_INT_CTRL, 8'h00);
	endtask
	task automatic t_ovr;
		wr(IDX_PC_DIR, 8'h04);
		periph_override_en_in <= 8'h14;
		periph_override_dir_in <= 8'h10;
		periph_level_in <= 8'h04;
		settle();
		chk("pc_oe_ovr", 32'hEF, peripheral_port_out.oe);
		chk("pc_pins", 32'h04, periph_pin_level_out & 8'hEF);
		rc(IDX_PC_DIR, 32'h04, "pc_dir_kept");
		periph_override_en_in <= 8'h00;
		settle();
		chk("pc_oe_back", 32'hFB, peripheral_port_out.oe);
		wr(IDX_PC_DIR, 8'hFF);
	endtask
	task automatic t_slave;
		parallel_slave_status_in <= 3'b110;
		wr(IDX_CTL_DIR, 8'h1F);
		rc(IDX_CTL_DIR, 32'hD7, "ctl_dir_rd");
		parallel_slave_bus_level_in <= 8'h3C;
		parallel_slave_bus_oe_in <= 1'b1;
		settle();
		chk("slave_en", 32'h1, parallel_slave_enable_out);
		chk("slave_ttl", 32'h00, parallel_schmitt_sel_out);
		chk("slave_drv", 32'h3C3C, {parallel_port_out.level, parallel_port_out.oe & 8'h3C});
		@(posedge ref_clk_in);
		parallel_slave_bus_oe_in <= 1'b0;
		ext_lvl <= 24'h960000;
		ext_en <= 24'hFF0000;
		settle();
		chk("slave_in", 32'h96, parallel_slave_bus_out);
		wr(IDX_CTL_DIR, 8'h07);
		parallel_slave_status_in <= 3'b000;
		settle();
		chk("port_schmitt", 32'hFF, parallel_schmitt_sel_out);
	endtask
	task automatic t_prog;
		@(posedge ref_clk_in);
		prog_mode_in <= 1'b1;
		ext_lvl <= 24'h0000C0;
		ext_en <= 24'h0000C0;
		settle();
		chk("prog_schmitt", 32'hC0, keypad_schmitt_sel_out & 8'hC0);
		chk("prog_clk", 32'h1, prog_clk_out);
		chk("prog_data", 32'h1, prog_data_out);
		@(posedge ref_clk_in);
		prog_mode_in <= 1'b0;
		settle();
		chk("run_schmitt", 32'h00, keypad_schmitt_sel_out & 8'h80);
	endtask
	initial begin
		#100000;
		n_errors++;
		summarize();
	end
	initial begin
		{rst_b_in, por_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in,
			s_axi_rready_in, prog_mode_in, prog_data_level_in, prog_data_oe_in, timer_osc_en_in,
			parallel_slave_bus_oe_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in,
			periph_override_en_in, periph_override_dir_in, periph_level_in,
			parallel_slave_bus_level_in, parallel_slave_status_in, ext_lvl, ext_en} = '0;
		s_axi_wstrb_in = 4'hF;
		repeat (8) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		por_b_in <= 1'b1;
		t_rst();
		t_latch();
		t_pull();
		t_chg();
		t_ovr();
		t_slave();
		t_prog();
		summarize();
	end
endmodule
